/* File: logic/fmcb_pkg.sv */
// Purpose: Constants for the fieldbus mode and configuration bank
// Assumes: APB slave, 32-bit data, one aligned word per register index
// Notes: Byte address of every register is four times its index
//
// Notes on behaviour
// - Mode zero pulse/direction, one rotation input
// - Boot delay milliseconds gates functional readiness
// - Low half interfaces, high half protocols
// - Fixed interface bits, USB through SPI
// - Protocol bits 16 to 18, rest zero
// - Availability read-only, resets to CAN only
// - Activation mask writable, resets to CAN
// - Switchable interfaces follow activation, active reported
// - Switchable bit one means may deactivate
// - Active bit one means active, reset CAN
`default_nettype none

package fmcb_pkg;

  // ------------------------------------------------------------
  // Register indexes and byte addresses
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] IDX_MODE = 16'h205b;
  localparam logic [ADDR_W-1:0] IDX_BOOT = 16'h2084;
  localparam logic [ADDR_W-1:0] IDX_AVAIL = 16'h2101;
  localparam logic [ADDR_W-1:0] IDX_ACT = 16'h2102;
  localparam logic [ADDR_W-1:0] IDX_SWITCH = 16'h2104;
  localparam logic [ADDR_W-1:0] IDX_ACTIVE = 16'h2105;
  localparam logic [ADDR_W-1:0] ADDR_MODE = IDX_MODE << 2;
  localparam logic [ADDR_W-1:0] ADDR_BOOT = IDX_BOOT << 2;
  localparam logic [ADDR_W-1:0] ADDR_AVAIL = IDX_AVAIL << 2;
  localparam logic [ADDR_W-1:0] ADDR_ACT = IDX_ACT << 2;
  localparam logic [ADDR_W-1:0] ADDR_SWITCH = IDX_SWITCH << 2;
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE = IDX_ACTIVE << 2;

  // ------------------------------------------------------------
  // Interface and protocol bit positions
  // ------------------------------------------------------------
  localparam int USB_BIT = 0;
  localparam int RS485_BIT = 1;
  localparam int RS232_BIT = 2;
  localparam int CAN_BIT = 3;
  localparam int ETHERNET_INTERFACE_BIT = 4;
  localparam int REALTIME_ETHERNET_FIELDBUS_BIT = 5;
  localparam int SPI_BIT = 6;
  localparam int MODBUS_SERIAL_PROTOCOL_BIT = 16;
  localparam int MODBUS_NETWORK_PROTOCOL_BIT = 17;
  localparam int INDUSTRIAL_IP_PROTOCOL_BIT = 18;
  localparam int MODE_SEL_BIT = 0;

  // Implemented bits: interfaces in the low half, protocols above
  localparam logic [31:0] IFACE_MASK = 32'h0000_007f;
  localparam logic [31:0] PROTO_MASK = 32'h0007_0000;
  localparam logic [31:0] VALID_MASK = IFACE_MASK | PROTO_MASK;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] BOOT_RESET = 32'h0000_0000;
  localparam logic [31:0] AVAIL_RESET = 32'h0000_0008;
  localparam logic [31:0] ACT_RESET = 32'h0000_0008;
  localparam logic [31:0] SWITCH_RESET = 32'h0000_0000;
  localparam logic [31:0] ACTIVE_RESET = 32'h0000_0008;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int BOOT_UNIT_NS = 1000000;
  localparam int CYCLES_PER_MS = BOOT_UNIT_NS / CLK_PERIOD_NS;

  // Boot sequencer states
  typedef enum logic {FMCB_BOOT_WAIT, FMCB_BOOT_READY} fmcb_boot_t;

endpackage

`default_nettype wire

/* File: logic/fmcb_boot_timer.sv */
// Purpose: Configuration bank with APB access and boot readiness timer
// Assumes: Single clock, APB slave with one wait-free access phase
// Notes: Readiness is sticky while supply stays good
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Boot readiness timer
// ------------------------------------------------------------
module fmcb_boot_timer #(
  parameter int CYCLES_PER_MS = fmcb_pkg::CYCLES_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [31:0] delay_ms,
  output logic ready
);

  logic [31:0] pre_cnt;
  logic [31:0] ms_cnt;
  logic delay_done;
  fmcb_pkg::fmcb_boot_t state;
  fmcb_pkg::fmcb_boot_t next_state;

  // Elapsed time compared with the live delay value
  assign delay_done = (ms_cnt >= delay_ms);

  // Next state, waiting restarts whenever supply drops
  always_comb begin
    next_state = state;
    if (!run) begin
      next_state = fmcb_pkg::FMCB_BOOT_WAIT;
    end else begin
      unique case (state)
        fmcb_pkg::FMCB_BOOT_WAIT: begin
          if (delay_done) begin
            next_state = fmcb_pkg::FMCB_BOOT_READY;
          end
        end
        fmcb_pkg::FMCB_BOOT_READY: begin
          next_state = fmcb_pkg::FMCB_BOOT_READY;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= fmcb_pkg::FMCB_BOOT_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // Prescaler and millisecond count, frozen once the delay is met
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= fmcb_pkg::ZERO_WORD;
      ms_cnt <= fmcb_pkg::ZERO_WORD;
    end else if (!run) begin
      pre_cnt <= fmcb_pkg::ZERO_WORD;
      ms_cnt <= fmcb_pkg::ZERO_WORD;
    end else if (!delay_done) begin
      if (pre_cnt == 32'(CYCLES_PER_MS - 1)) begin
        pre_cnt <= fmcb_pkg::ZERO_WORD;
        ms_cnt <= ms_cnt + 32'h0000_0001;
      end else begin
        pre_cnt <= pre_cnt + 32'h0000_0001;
      end
    end
  end

  // Readiness flag, a flip-flop so the top output stays registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready <= 1'b0;
    end else begin
      ready <= (next_state == fmcb_pkg::FMCB_BOOT_READY);
    end
  end

endmodule // fmcb_boot_timer

// ------------------------------------------------------------
// Configuration bank top
// ------------------------------------------------------------
module fmcb_bank #(
  parameter int CYCLES_PER_MS = fmcb_pkg::CYCLES_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  input wire logic supply_good,
  input wire logic [31:0] switch_mask,
  output logic mode_sel,
  output logic boot_ready,
  output logic [31:0] active_mask
);

  // ------------------------------------------------------------
  // Bus phase decode
  // ------------------------------------------------------------
  logic setup_ph;
  logic wr_commit;
  logic hit_mode;
  logic hit_boot;
  logic hit_avail;
  logic hit_act;
  logic hit_switch;
  logic hit_active;
  logic [31:0] mode_reg;
  logic [31:0] boot_reg;
  logic [31:0] act_reg;
  logic [31:0] sw_reg;
  logic [31:0] next_rdata;

  // Setup phase launches the answer, commit only when ready is seen
  assign setup_ph = psel & ~penable;
  assign wr_commit = psel & penable & pready & pwrite;

  // Register address match, byte address is four times the index
  assign hit_mode = (paddr == fmcb_pkg::ADDR_MODE);
  assign hit_boot = (paddr == fmcb_pkg::ADDR_BOOT);
  assign hit_avail = (paddr == fmcb_pkg::ADDR_AVAIL);
  assign hit_act = (paddr == fmcb_pkg::ADDR_ACT);
  assign hit_switch = (paddr == fmcb_pkg::ADDR_SWITCH);
  assign hit_active = (paddr == fmcb_pkg::ADDR_ACTIVE);

  // ------------------------------------------------------------
  // Bus answer
  // ------------------------------------------------------------

  // Ready one cycle after setup, so every access has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ph;
    end
  end

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    next_rdata = fmcb_pkg::ZERO_WORD;
    case (paddr)
      fmcb_pkg::ADDR_MODE: begin
        next_rdata = mode_reg;
      end
      fmcb_pkg::ADDR_BOOT: begin
        next_rdata = boot_reg;
      end
      fmcb_pkg::ADDR_AVAIL: begin
        next_rdata = fmcb_pkg::AVAIL_RESET;
      end
      fmcb_pkg::ADDR_ACT: begin
        next_rdata = act_reg;
      end
      fmcb_pkg::ADDR_SWITCH: begin
        next_rdata = sw_reg;
      end
      fmcb_pkg::ADDR_ACTIVE: begin
        next_rdata = active_mask;
      end
      default: begin
        next_rdata = fmcb_pkg::ZERO_WORD;
      end
    endcase
  end

  // Read data captured in setup and held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= fmcb_pkg::ZERO_WORD;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------

  // Input mode word, bit zero picks the handling downstream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= fmcb_pkg::MODE_RESET;
      mode_sel <= fmcb_pkg::MODE_RESET[fmcb_pkg::MODE_SEL_BIT];
    end else if (wr_commit && hit_mode) begin
      mode_reg <= pwdata;
      mode_sel <= pwdata[fmcb_pkg::MODE_SEL_BIT];
    end
  end

  // Boot delay in milliseconds, read live by the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= fmcb_pkg::BOOT_RESET;
    end else if (wr_commit && hit_boot) begin
      boot_reg <= pwdata;
    end
  end

  // Activation mask, unused bits dropped so they always read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= fmcb_pkg::ACT_RESET;
    end else if (wr_commit && hit_act) begin
      act_reg <= pwdata & fmcb_pkg::VALID_MASK;
    end
  end

  // Writes to the availability word are ignored: no storage exists
  // for it, so it can never drift from its fixed value

  // ------------------------------------------------------------
  // Status object links
  // ------------------------------------------------------------

  // Switchable set from the platform, registered to keep it glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_reg <= fmcb_pkg::SWITCH_RESET;
    end else begin
      sw_reg <= switch_mask & fmcb_pkg::VALID_MASK;
    end
  end

  // Active set: switchable bits follow activation, the rest hold.
  // One cycle behind a write, so a read whose setup follows it at once returns the old value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_mask <= fmcb_pkg::ACTIVE_RESET;
    end else begin
      active_mask <= (active_mask & ~sw_reg)
        | (act_reg & sw_reg);
    end
  end

  // ------------------------------------------------------------
  // Readiness
  // ------------------------------------------------------------

  // Timer restarts each time supply goes good
  fmcb_boot_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_fmcb_boot_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(supply_good),
    .delay_ms(boot_reg),
    .ready(boot_ready)
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb_bank @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Mode write lands in the word and the select bit
  property p_mode_write;
    (wr_commit && hit_mode) |=> ((mode_reg == $past(pwdata))
      && (mode_sel == $past(pwdata[fmcb_pkg::MODE_SEL_BIT])));
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write not stored");

  // Readiness only after supply was good
  property p_ready_supply;
    boot_ready |-> $past(supply_good);
  endproperty
  a_ready_supply: assert property (p_ready_supply)
    else $error("ready without supply");

  // Unused bits stay clear in both masks
  property p_unused_zero;
    ((active_mask & ~fmcb_pkg::VALID_MASK) == fmcb_pkg::ZERO_WORD)
      && ((act_reg & ~fmcb_pkg::VALID_MASK) == fmcb_pkg::ZERO_WORD);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused mask bit set");

  // Availability always answers its fixed value
  property p_avail_read;
    (setup_ph && !pwrite && hit_avail)
      |=> (prdata == fmcb_pkg::AVAIL_RESET);
  endproperty
  a_avail_read: assert property (p_avail_read)
    else $error("availability read wrong");

  // Activation write stores the implemented bits
  property p_act_write;
    (wr_commit && hit_act)
      |=> (act_reg == ($past(pwdata) & fmcb_pkg::VALID_MASK));
  endproperty
  a_act_write: assert property (p_act_write)
    else $error("activation write not stored");

  // Switchable bits follow the activation mask
  property p_active_follow;
    1'b1 |=> ((active_mask & $past(sw_reg))
      == ($past(act_reg) & $past(sw_reg)));
  endproperty
  a_active_follow: assert property (p_active_follow)
    else $error("switchable bit not following");

  // Other bits keep their state
  property p_active_keep;
    1'b1 |=> ((active_mask & ~$past(sw_reg))
      == ($past(active_mask) & ~$past(sw_reg)));
  endproperty
  a_active_keep: assert property (p_active_keep)
    else $error("fixed interface changed");

  // Main scenarios reached
  c_mode_rotation: cover property (wr_commit && hit_mode && pwdata[0]);
  c_ready_rise: cover property ($rose(boot_ready));
  c_act_write: cover property (wr_commit && hit_act);

endmodule // fmcb_bank

`default_nettype wire

/* File: tb/fieldbus_mode_config_bank_bench.sv */
// Purpose: Self-checking bench for the configuration bank over APB
// Assumes: A short millisecond of 4 cycles keeps the run brief
// Notes: Readiness latency is counted from supply going good
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module fieldbus_mode_config_bank_bench;
  localparam int MS_CYC = 4;
  localparam logic [31:0] SW = 32'h0001_0011;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic supply_good = 1'b0;
  logic [31:0] switch_mask = SW;
  logic mode_sel;
  logic ready;
  logic [31:0] active_mask;
  logic [31:0] r;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  fmcb_bank #(.CYCLES_PER_MS(MS_CYC)) u_fmcb_bank (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .supply_good(supply_good),
    .switch_mask(switch_mask),
    .mode_sel(mode_sel),
    .boot_ready(ready),
    .active_mask(active_mask)
  );
  // Clock source, 8 ns period
  initial begin
    forever #4 pclk = ~pclk;
  end
  // APB write: setup, access, hold until pready is sampled high
  task automatic apb_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= 1'b1;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // APB read: data taken at the edge where pready is sampled high
  task automatic apb_read(input logic [15:0] a, output logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the roughly 140 cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Supply off, load delay, supply on, count cycles until ready
  task automatic boot(input logic [31:0] d, output int c);
    c = 0;
    supply_good <= 1'b0;
    apb_write(fmcb_pkg::ADDR_BOOT, d);
    @(posedge pclk);
    supply_good <= 1'b1;
    do begin
      @(posedge pclk);
      #1;
      c++;
    end while (ready !== 1'b1 && c < 100);
  endtask
  // Register scenarios, then three boot delays
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb_read(fmcb_pkg::ADDR_MODE, r);
    `CHK("mode rst", 32'h0000_0000, r)
    apb_read(fmcb_pkg::ADDR_BOOT, r);
    `CHK("boot rst", 32'h0000_0000, r)
    apb_read(fmcb_pkg::ADDR_AVAIL, r);
    `CHK("avail rst", 32'h0000_0008, r)
    apb_read(fmcb_pkg::ADDR_ACT, r);
    `CHK("act rst", 32'h0000_0008, r)
    apb_read(fmcb_pkg::ADDR_ACTIVE, r);
    `CHK("active rst", 32'h0000_0008, r)
    apb_read(fmcb_pkg::ADDR_SWITCH, r);
    `CHK("switch", SW, r)
    apb_write(fmcb_pkg::ADDR_MODE, 32'h0000_0001);
    apb_read(fmcb_pkg::ADDR_MODE, r);
    `CHK("mode one", 32'h0000_0001, r)
    `CHK("mode_sel one", 1'b1, mode_sel)
    apb_write(fmcb_pkg::ADDR_MODE, 32'h0000_0000);
    apb_read(fmcb_pkg::ADDR_MODE, r);
    `CHK("mode_sel zero", 1'b0, mode_sel)
    apb_write(fmcb_pkg::ADDR_AVAIL, 32'hffff_ffff);
    apb_read(fmcb_pkg::ADDR_AVAIL, r);
    `CHK("avail ro", 32'h0000_0008, r)
    apb_write(fmcb_pkg::ADDR_ACT, 32'hffff_ffff);
    apb_read(fmcb_pkg::ADDR_ACT, r);
    `CHK("act unused", 32'h0007_007f, r)
    apb_read(fmcb_pkg::ADDR_ACTIVE, r);
    `CHK("active all", 32'h0001_0019, r)
    `CHK("active port", 32'h0001_0019, active_mask)
    apb_write(fmcb_pkg::ADDR_ACT, 32'h0000_0001);
    apb_read(fmcb_pkg::ADDR_ACTIVE, r);
    `CHK("active usb", 32'h0000_0009, r)
    apb_write(fmcb_pkg::ADDR_ACT, 32'h0001_0000);
    apb_read(fmcb_pkg::ADDR_ACTIVE, r);
    `CHK("active proto", 32'h0001_0008, r)
    apb_write(fmcb_pkg::ADDR_ACT, 32'h0000_0000);
    apb_read(fmcb_pkg::ADDR_ACTIVE, r);
    `CHK("active keep", 32'h0000_0008, r)
    `CHK("active port keep", 32'h0000_0008, active_mask)
    boot(32'h0000_0003, n);
    `CHK("ready 3ms", 32'(3 * MS_CYC + 1), 32'(n))
    apb_read(fmcb_pkg::ADDR_BOOT, r);
    `CHK("boot rd", 32'h0000_0003, r)
    repeat (20) @(posedge pclk);
    `CHK("ready held", 1'b1, ready)
    boot(32'h0000_0005, n);
    `CHK("ready 5ms", 32'(5 * MS_CYC + 1), 32'(n))
    boot(32'h0000_0000, n);
    `CHK("ready 0ms", 32'h0000_0001, 32'(n))
    complete_run();
  end
endmodule // fieldbus_mode_config_bank_bench
`default_nettype wire
